//--- ea_gen_pkg.sv
`default_nettype none
package ea_gen_pkg;
    // Addressing mode select codes
    localparam logic [2:0] MODE_INHERENT = 3'h0;
    localparam logic [2:0] MODE_IMMEDIATE = 3'h1;
    localparam logic [2:0] MODE_DIRECT = 3'h2;
    localparam logic [2:0] MODE_FULL_ADDRESS = 3'h3;
    localparam logic [2:0] MODE_INDEX_ONLY = 3'h4;
    localparam logic [2:0] MODE_INDEX_BYTE_OFFSET = 3'h5;
    // Instruction lengths in bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    // Reset values, and the zero high byte for page-zero addresses
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] HIGH_ZERO = 8'h00;
    // Highest address reachable with byte-offset indexing
    localparam logic [15:0] INDEX_OFFSET_LIMIT = 16'h01fe;
endpackage : ea_gen_pkg
`default_nettype wire

//--- effective_address_gen.sv
`default_nettype none
module effective_address_gen (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    // Decode request
    input wire logic STEP_I,
    input wire logic [2:0] MODE_I,
    input wire logic IS_JUMP_I,
    // Program state and operand bytes
    input wire logic [7:0] INDEX_I,
    input wire logic [7:0] BYTE1_I,
    input wire logic [7:0] BYTE2_I,
    // Results
    output logic [7:0] ADDR_HIGH_O,
    output logic [7:0] ADDR_LOW_O,
    output logic ADDR_VALID_O,
    output logic [15:0] PC_O,
    output logic BAD_MODE_O
);
    import ea_gen_pkg::*;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] operand_address;
        logic valid;
        logic bad_mode;
    } state_type;

    state_type cur;
    state_type next_cur;
    logic [8:0] index_sum;

    // Unsigned 8+8 sum, carry in bit 8
    assign index_sum = {1'b0, INDEX_I} + {1'b0, BYTE1_I};

    // Address and program counter per mode
    always_comb begin
        next_cur = cur;
        next_cur.valid = 1'b0;
        if (STEP_I) begin
            next_cur.bad_mode = 1'b0;
            next_cur.valid = 1'b1;
            case (MODE_I)
                MODE_INHERENT: begin
                    // No operand bytes used, address bus holds
                    next_cur.valid = 1'b0;
                    next_cur.pc = cur.pc + LEN_ONE;
                end
                MODE_IMMEDIATE: begin
                    next_cur.operand_address = cur.pc + LEN_ONE;
                    next_cur.pc = cur.pc + LEN_TWO;
                end
                MODE_DIRECT: begin
                    next_cur.operand_address = {HIGH_ZERO, BYTE1_I};
                    next_cur.pc = cur.pc + LEN_TWO;
                end
                MODE_FULL_ADDRESS: begin
                    next_cur.operand_address = {BYTE1_I, BYTE2_I};
                    // Jumps load the full 16-bit target
                    if (IS_JUMP_I) begin
                        next_cur.pc = {BYTE1_I, BYTE2_I};
                    end else begin
                        next_cur.pc = cur.pc + LEN_THREE;
                    end
                end
                MODE_INDEX_ONLY: begin
                    next_cur.operand_address = {HIGH_ZERO, INDEX_I};
                    next_cur.pc = cur.pc + LEN_ONE;
                end
                MODE_INDEX_BYTE_OFFSET: begin
                    // Carry forms the high byte: at most 0x01fe
                    next_cur.operand_address =
                        {7'h00, index_sum};
                    next_cur.pc = cur.pc + LEN_TWO;
                end
                default: begin
                    next_cur.valid = 1'b0;
                    next_cur.bad_mode = 1'b1;
                    next_cur.pc = cur.pc + LEN_ONE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cur.pc <= PC_RESET;
            cur.operand_address <= ADDR_RESET;
            cur.valid <= 1'b0;
            cur.bad_mode <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Both bus bytes from one register, same cycle
    assign ADDR_HIGH_O = cur.operand_address[15:8];
    assign ADDR_LOW_O = cur.operand_address[7:0];
    assign ADDR_VALID_O = cur.valid;
    assign PC_O = cur.pc;
    assign BAD_MODE_O = cur.bad_mode;

    // Step requests as seen at the taking edge
    sequence s_inherent_step;
        STEP_I && MODE_I == MODE_INHERENT;
    endsequence
    sequence s_immediate_step;
        STEP_I && MODE_I == MODE_IMMEDIATE;
    endsequence
    sequence s_direct_step;
        STEP_I && MODE_I == MODE_DIRECT;
    endsequence
    sequence s_full_step;
        STEP_I && MODE_I == MODE_FULL_ADDRESS && !IS_JUMP_I;
    endsequence
    sequence s_jump_step;
        STEP_I && MODE_I == MODE_FULL_ADDRESS && IS_JUMP_I;
    endsequence
    sequence s_index_step;
        STEP_I && MODE_I == MODE_INDEX_ONLY;
    endsequence
    sequence s_offset_step;
        STEP_I && MODE_I == MODE_INDEX_BYTE_OFFSET;
    endsequence
    // Illegal codes lie above the highest mode
    sequence s_bad_step;
        STEP_I && MODE_I > MODE_INDEX_BYTE_OFFSET;
    endsequence
    // Any legal mode, inherent included
    sequence s_legal_step;
        STEP_I && MODE_I <= MODE_INDEX_BYTE_OFFSET;
    endsequence
    // Legal modes that form an operand address
    sequence s_addr_step;
        STEP_I && MODE_I != MODE_INHERENT
        && MODE_I <= MODE_INDEX_BYTE_OFFSET;
    endsequence

    // Immediate: operand right after the opcode
    a_immediate_address: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_immediate_step |=>
        {ADDR_HIGH_O, ADDR_LOW_O} == $past(PC_O) + LEN_ONE)
        else $error("immediate address not pc plus one");
    a_immediate_pc: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_immediate_step |=>
        PC_O == $past(PC_O) + LEN_TWO)
        else $error("immediate pc step wrong");
    // Inherent: one byte, no access, bus holds
    a_inherent_step: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_inherent_step |=>
        PC_O == $past(PC_O) + LEN_ONE && !ADDR_VALID_O)
        else $error("inherent step wrong");
    a_inherent_holds: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_inherent_step |=>
        $stable({ADDR_HIGH_O, ADDR_LOW_O}))
        else $error("inherent step moved the address");
    // Direct: page zero, low byte from the operand
    a_direct_address: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_direct_step |=>
        ADDR_HIGH_O == HIGH_ZERO && ADDR_LOW_O == $past(BYTE1_I)
        && ADDR_VALID_O)
        else $error("direct address wrong");
    a_direct_pc: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_direct_step |=>
        PC_O == $past(PC_O) + LEN_TWO)
        else $error("direct pc step wrong");
    // Extended: two operand bytes, high first
    a_full_address: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_full_step |=>
        ADDR_HIGH_O == $past(BYTE1_I) && ADDR_LOW_O == $past(BYTE2_I)
        && PC_O == $past(PC_O) + LEN_THREE)
        else $error("extended address wrong");
    a_jump_target: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_jump_step |=>
        PC_O == {$past(BYTE1_I), $past(BYTE2_I)})
        else $error("jump target wrong");
    a_jump_address: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_jump_step |=>
        {ADDR_HIGH_O, ADDR_LOW_O} == {$past(BYTE1_I), $past(BYTE2_I)})
        else $error("jump address wrong");
    // Indexed modes: index alone or plus one byte
    a_index_only: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_index_step |=>
        ADDR_HIGH_O == HIGH_ZERO && ADDR_LOW_O == $past(INDEX_I)
        && PC_O == $past(PC_O) + LEN_ONE)
        else $error("index only address wrong");
    a_index_offset: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_offset_step |=>
        {ADDR_HIGH_O, ADDR_LOW_O} ==
        16'($past(INDEX_I)) + 16'($past(BYTE1_I))
        && PC_O == $past(PC_O) + LEN_TWO)
        else $error("byte offset address wrong");
    a_offset_limit: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_offset_step |=>
        {ADDR_HIGH_O, ADDR_LOW_O} <= INDEX_OFFSET_LIMIT)
        else $error("byte offset beyond reach");
    // Valid pulse per addressing step, quiet otherwise
    a_valid_pulse: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_addr_step |=> ADDR_VALID_O)
        else $error("address step without valid");
    a_valid_hold: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        !STEP_I |=> !ADDR_VALID_O && $stable(PC_O)
        && $stable({ADDR_HIGH_O, ADDR_LOW_O}))
        else $error("outputs moved without step");
    // Illegal codes: flag, skip one byte, no access
    a_bad_flag: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_bad_step |=>
        BAD_MODE_O && !ADDR_VALID_O && PC_O == $past(PC_O) + LEN_ONE
        && $stable({ADDR_HIGH_O, ADDR_LOW_O}))
        else $error("illegal mode not refused");
    a_bad_clear: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        s_legal_step |=> !BAD_MODE_O)
        else $error("bad mode flag not cleared");
    a_bad_sticky: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        !STEP_I |=> $stable(BAD_MODE_O))
        else $error("bad mode flag moved without step");
endmodule : effective_address_gen
`default_nettype wire

//--- mem_model.sv
`default_nettype none
module mem_model (
    // Bus from the generator
    input wire logic clk_i,
    input wire logic [7:0] high_i,
    input wire logic [7:0] low_i,
    input wire logic valid_i,
    // Access count and read byte
    output logic [15:0] hits_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count accesses; idle data toggles so a stale byte never holds for two cycles
    initial hits_o = 16'h0000;
    initial data_o = 8'h00;
    always @(posedge clk_i) begin
        if (valid_i) begin
            hits_o <= hits_o + 16'h0001;
            data_o <= high_i ^ low_i;
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule : mem_model
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ea_gen_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, step = 1'b0, jmp = 1'b0, vld, bad;
    logic [2:0] mode = 3'h0;
    logic [7:0] idx = 8'h00, b1 = 8'h00, b2 = 8'h00, hi, lo, data;
    logic [15:0] pc_o, hits, pc = 16'h0000, last_addr = 16'h0000;
    int miscompares = 0, comparisons = 0;
    // Clock and instances
    always #2.5 clk = ~clk;
    effective_address_gen dut (.SYS_CLK_I(clk), .RESETN_I(rst_n),
        .STEP_I(step), .MODE_I(mode), .IS_JUMP_I(jmp), .INDEX_I(idx),
        .BYTE1_I(b1), .BYTE2_I(b2), .ADDR_HIGH_O(hi), .ADDR_LOW_O(lo),
        .ADDR_VALID_O(vld), .PC_O(pc_o), .BAD_MODE_O(bad));
    mem_model mem (.clk_i(clk), .high_i(hi), .low_i(lo), .valid_i(vld),
        .hits_o(hits), .data_o(data));
    // Verdict and end of run
    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One step, outputs judged one cycle later
    task st(input logic [2:0] m, input logic j, input logic [7:0] x, a,
        b, input logic [15:0] e, input logic v, bd, input logic [15:0] np);
        @(negedge clk);
        {step, mode, jmp, idx, b1, b2} = {1'b1, m, j, x, a, b};
        @(negedge clk);
        step = 1'b0;
        chk("addr", e, {hi, lo});
        chk("valid", {15'h0, v}, {15'h0, vld});
        chk("bad", {15'h0, bd}, {15'h0, bad});
        chk("pc", np, pc_o);
        pc = np;
        last_addr = e;
    endtask : st
    task t_direct;
        st(MODE_DIRECT, 1'b0, 8'h77, 8'h40, 8'h99,
            16'h0040, 1'b1, 1'b0, pc + 16'h0002);
        @(negedge clk);
        chk("valid drop", 16'h0000, {15'h0, vld});
        chk("mem data", 16'h0040, {8'h00, data});
    endtask : t_direct
    task t_imm;
        st(MODE_IMMEDIATE, 1'b0, 8'h11, 8'h5a, 8'h22,
            pc + 16'h0001, 1'b1, 1'b0, pc + 16'h0002);
    endtask : t_imm
    task t_full;
        st(MODE_FULL_ADDRESS, 1'b0, 8'h03, 8'h12, 8'h34,
            16'h1234, 1'b1, 1'b0, pc + 16'h0003);
        st(MODE_FULL_ADDRESS, 1'b1, 8'h03, 8'hfe, 8'hcd,
            16'hfecd, 1'b1, 1'b0, 16'hfecd);
    endtask : t_full
    task t_index;
        st(MODE_INDEX_ONLY, 1'b0, 8'h9a, 8'h44, 8'h55,
            16'h009a, 1'b1, 1'b0, pc + 16'h0001);
        st(MODE_INDEX_BYTE_OFFSET, 1'b0, 8'h10, 8'h20, 8'h66,
            16'h0030, 1'b1, 1'b0, pc + 16'h0002);
        st(MODE_INDEX_BYTE_OFFSET, 1'b0, 8'hff, 8'hff, 8'h00,
            16'h01fe, 1'b1, 1'b0, pc + 16'h0002);
    endtask : t_index
    task t_refuse;
        st(MODE_INHERENT, 1'b0, 8'h33, 8'h01, 8'h02,
            last_addr, 1'b0, 1'b0, pc + 16'h0001);
        st(3'h6, 1'b0, 8'h33, 8'h01, 8'h02,
            last_addr, 1'b0, 1'b1, pc + 16'h0001);
        st(3'h7, 1'b0, 8'h33, 8'h01, 8'h02,
            last_addr, 1'b0, 1'b1, pc + 16'h0001);
        @(negedge clk);
        chk("bad sticky", 16'h0001, {15'h0, bad});
        st(MODE_DIRECT, 1'b0, 8'h00, 8'hff, 8'h00,
            16'h00ff, 1'b1, 1'b0, pc + 16'h0002);
    endtask : t_refuse
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        chk("reset pc", PC_RESET, pc_o);
        chk("reset addr", ADDR_RESET, {hi, lo});
        chk("reset flags", 16'h0000, {14'h0, vld, bad});
        rst_n = 1'b1;
        t_direct();
        t_imm();
        t_full();
        t_index();
        t_refuse();
        // Let the memory count the last valid pulse
        @(negedge clk);
        chk("accesses", 16'h0008, hits);
        summarize();
    end
endmodule : testbench
`default_nettype wire
